// ==== hw/iesr_pkg.sv ====
// Purpose: Constants and types for the interrupt set-enable register block
// Assumes: One AHB-Lite slave, 32-bit data, word registers, core_clk at 100 MHz
// Notes:   Enable state for interrupts 0-49; number 39 and 12-14 are not built
//
// How it works
// - Writing one to an implemented set-enable bit turns that interrupt on.
// - Writing zero leaves the enable untouched; set-enable writes never disable.
// - Reading a set-enable register returns the present enable of each interrupt.
// - Low word bits 31-15,11-0 are interrupts 31-15,11-0; high word 17-8,6-0 are 49-40,38-32.
package iesr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [11:0] IESR_SET_LOW_OFF  = 12'h000;
  localparam logic [11:0] IESR_SET_HIGH_OFF = 12'h004;
  localparam int          IESR_DEC_MSB      = 11;
  localparam logic [31:0] IESR_SET_LOW_RST  = 32'h0000_0000;
  localparam logic [31:0] IESR_SET_HIGH_RST = 32'h0000_0000;
  localparam logic [31:0] IESR_RD_UNMAPPED  = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Implemented positions
  localparam logic [31:0] IESR_IMPL_LOW  = 32'hffff_8fff;
  localparam logic [31:0] IESR_IMPL_HIGH = 32'h0003_ff7f;
  localparam logic [63:0] IESR_IMPL_ALL  = {IESR_IMPL_HIGH, IESR_IMPL_LOW};
  localparam int          IESR_NUM_IRQ   = 50;
  localparam int          IESR_HOLE_IRQ  = 39;

  ////////////////////////////////////////////////////////////////////////////
  // Bus encodings
  localparam logic [1:0] IESR_HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] IESR_HTRANS_NONSEQ = 2'h2;
  localparam logic       IESR_HRESP_OKAY    = 1'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0]
  {
    IESR_ST_IDLE  = 2'h0,
    IESR_ST_WRITE = 2'h2,
    IESR_ST_READ  = 2'h1
  } iesr_state_type;

  typedef struct packed
  {
    logic sel_high;
    logic sel_low;
  } iesr_sel_type;

endpackage : iesr_pkg

// ==== hw/iesr_bank.sv ====
// Purpose: Enable flip-flops, one per implemented interrupt position
// Assumes: Set and clear vectors are one-cycle pulses on core_clk
// Notes:   A set in the same cycle as a clear wins
`timescale 1ns/1ps

module iesr_bank
  import iesr_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Set and clear pulses, low word in bits 31:0
  input  wire logic [63:0] set_bits,
  input  wire logic [63:0] clear_bits,
  // Enable state
  output logic      [63:0] enable_q
);

  ////////////////////////////////////////////////////////////////////////////
  // One cell per position; unbuilt positions are constant zero
  genvar i;
  generate
    for (i = 0; i < 64; i++)
    begin : g_cell
      if (IESR_IMPL_ALL[i])
      begin : g_impl
        logic en_q;
        logic en_d;
        always_comb
        begin
          en_d = en_q;
          if (clear_bits[i])
            en_d = 1'b0;
          if (set_bits[i])
            en_d = 1'b1;
        end
        always_ff @(posedge core_clk or negedge rst_n)
        begin
          if (!rst_n)
            en_q <= 1'b0;
          else
            en_q <= en_d;
        end
        // One driver per output bit, so no process shares the vector
        assign enable_q[i] = en_q;
      end
      else
      begin : g_hole
        assign enable_q[i] = 1'b0;
      end
    end
  endgenerate

endmodule : iesr_bank

// ==== hw/iesr_top.sv ====
// Purpose: AHB-Lite slave holding the two interrupt set-enable registers
// Assumes: Single slave on the bus, word transfers, core_clk at 100 MHz
// Notes:   Writes take no wait state; reads take one so data reflect prior writes
`timescale 1ns/1ps

module iesr_top
  import iesr_pkg::*;
(
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  // AHB-Lite slave
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic      [31:0]              hrdata,
  output logic                          hresp,
  // Clear pulses from the clear-enable side, indexed by interrupt number
  input  wire logic [IESR_NUM_IRQ-1:0]  irq_enable_clear_bits,
  // Enable state, indexed by interrupt number
  output logic      [IESR_NUM_IRQ-1:0]  irq_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus state
  iesr_state_type  state_q;
  iesr_state_type  state_d;
  iesr_sel_type    sel_q;
  iesr_sel_type    sel_d;
  logic            hreadyout_q;
  logic            hreadyout_d;
  logic [31:0]     hrdata_q;
  logic [31:0]     hrdata_d;
  logic            hresp_q;
  logic            hresp_d;

  logic            addr_taken;
  iesr_sel_type    addr_sel;
  logic [63:0]     set_bits;
  logic [63:0]     clear_bits;
  logic [63:0]     enable_q;
  logic [31:0]     en_low;
  logic [31:0]     en_high;

  ////////////////////////////////////////////////////////////////////////////
  // Address phase decode
  // hsize is not checked: only word transfers are issued to this block
  assign addr_taken = hsel && htrans[1] && hready;

  always_comb
  begin
    addr_sel          = '0;
    addr_sel.sel_low  = (haddr[IESR_DEC_MSB:0] == IESR_SET_LOW_OFF);
    addr_sel.sel_high = (haddr[IESR_DEC_MSB:0] == IESR_SET_HIGH_OFF);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencing
  always_comb
  begin
    state_d     = state_q;
    sel_d       = sel_q;
    hreadyout_d = hreadyout_q;
    hrdata_d    = hrdata_q;
    hresp_d     = IESR_HRESP_OKAY;
    case (state_q)
      IESR_ST_IDLE,
      IESR_ST_WRITE:
      begin
        hreadyout_d = 1'b1;
        state_d     = IESR_ST_IDLE;
        sel_d       = '0;
        if (addr_taken)
        begin
          sel_d = addr_sel;
          if (hwrite)
            state_d = IESR_ST_WRITE;
          else
          begin
            // Wait one cycle so a write in its data phase lands first
            state_d     = IESR_ST_READ;
            hreadyout_d = 1'b0;
          end
        end
      end
      IESR_ST_READ:
      begin
        hreadyout_d = 1'b1;
        state_d     = IESR_ST_IDLE;
        sel_d       = '0;
        if (sel_q.sel_low)
          hrdata_d = en_low;
        else if (sel_q.sel_high)
          hrdata_d = en_high;
        else
          hrdata_d = IESR_RD_UNMAPPED;
      end
      default:
      begin
        state_d     = IESR_ST_IDLE;
        sel_d       = '0;
        hreadyout_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q     <= IESR_ST_IDLE;
      sel_q       <= '0;
      hreadyout_q <= 1'b1;
      hrdata_q    <= IESR_RD_UNMAPPED;
      hresp_q     <= IESR_HRESP_OKAY;
    end
    else
    begin
      state_q     <= state_d;
      sel_q       <= sel_d;
      hreadyout_q <= hreadyout_d;
      hrdata_q    <= hrdata_d;
      hresp_q     <= hresp_d;
    end
  end

  assign hreadyout = hreadyout_q;
  assign hrdata    = hrdata_q;
  assign hresp     = hresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Enable state
  // A zero in hwdata produces no pulse, so a set-enable write cannot disable
  always_comb
  begin
    set_bits = '0;
    if (state_q == IESR_ST_WRITE && sel_q.sel_low)
      set_bits[31:0] = hwdata & IESR_IMPL_LOW;
    if (state_q == IESR_ST_WRITE && sel_q.sel_high)
      set_bits[63:32] = hwdata & IESR_IMPL_HIGH;
  end

  // Interrupt 39 has no cell, so its clear input is unused
  assign clear_bits = {14'h0000, irq_enable_clear_bits[49:40], 1'b0,
                       irq_enable_clear_bits[38:32], irq_enable_clear_bits[31:0]};

  iesr_bank i_iesr_bank
  (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .set_bits   (set_bits),
    .clear_bits (clear_bits),
    .enable_q   (enable_q)
  );

  assign en_low  = enable_q[31:0];
  assign en_high = enable_q[63:32];
  assign irq_en  = {en_high[17:8], 1'b0, en_high[6:0], en_low};

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic wr_low_stb;
  logic wr_high_stb;
  assign wr_low_stb  = (state_q == IESR_ST_WRITE) && sel_q.sel_low;
  assign wr_high_stb = (state_q == IESR_ST_WRITE) && sel_q.sel_high;

  sequence s_rd_low_req;
    addr_taken && !hwrite && addr_sel.sel_low;
  endsequence

  sequence s_rd_high_req;
    addr_taken && !hwrite && addr_sel.sel_high;
  endsequence

  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  sequence s_rd_req;
    addr_taken && !hwrite;
  endsequence

  sequence s_wr_req;
    addr_taken && hwrite;
  endsequence

  sequence s_rd_unmapped_req;
    addr_taken && !hwrite && !addr_sel.sel_low && !addr_sel.sel_high;
  endsequence

  sequence s_wr_unmapped_req;
    addr_taken && hwrite && !addr_sel.sel_low && !addr_sel.sel_high;
  endsequence

  set_low_bit_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr_low_stb |=> ((en_low & $past(hwdata) & IESR_IMPL_LOW) == ($past(hwdata) & IESR_IMPL_LOW)))
    else $error("low set-enable write did not turn on written bits");

  set_high_bit_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr_high_stb |=> ((en_high & $past(hwdata) & IESR_IMPL_HIGH) == ($past(hwdata) & IESR_IMPL_HIGH)))
    else $error("high set-enable write did not turn on written bits");

  zero_keeps_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (wr_low_stb || wr_high_stb) && (irq_enable_clear_bits == '0)
      |=> ((enable_q & ~$past(set_bits)) == ($past(enable_q) & ~$past(set_bits))))
    else $error("set-enable write changed a bit written as zero");

  read_low_value_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_rd_low_req |=> s_rd_wait ##0 (hrdata == $past(en_low)))
    else $error("low read data differ from enable state");

  read_high_value_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_rd_high_req |=> s_rd_wait ##0 (hrdata == $past(en_high)))
    else $error("high read data differ from enable state");

  irq_map_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (irq_en[31:0] == en_low) && (irq_en[38:32] == en_high[6:0]) &&
    (irq_en[49:40] == en_high[17:8]) && !irq_en[IESR_HOLE_IRQ])
    else $error("interrupt enable map broken");

  reserved_zero_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ((en_low & ~IESR_IMPL_LOW) == '0) && ((en_high & ~IESR_IMPL_HIGH) == '0))
    else $error("unimplemented enable position became set");

  reset_clear_a: assert property (
    @(posedge core_clk)
    !rst_n |=> (enable_q == '0) || !rst_n)
    else $error("enables not cleared by reset");

  clear_drop_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (state_q != IESR_ST_WRITE) && irq_enable_clear_bits[0] |=> !irq_en[0])
    else $error("clear pulse did not disable interrupt 0");

  resp_okay_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    hresp == IESR_HRESP_OKAY)
    else $error("slave answered other than OKAY");

  ////////////////////////////////////////////////////////////////////////////
  // Bus timing and enable bookkeeping
  write_no_wait_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_wr_req |=> hreadyout)
    else $error("write data phase was stretched");

  read_one_wait_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_rd_req |=> s_rd_wait)
    else $error("read did not take exactly one wait state");

  ready_low_once_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !hreadyout |=> hreadyout)
    else $error("hreadyout held low for more than one cycle");

  unmapped_read_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_rd_unmapped_req |=> s_rd_wait ##0 (hrdata == IESR_RD_UNMAPPED))
    else $error("unmapped read returned nonzero data");

  unmapped_write_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_wr_unmapped_req |=> (set_bits == '0))
    else $error("unmapped write produced set pulses");

  rdata_hold_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (state_q != IESR_ST_READ) |=> $stable(hrdata))
    else $error("read data changed outside a read");

  // Set beats clear so an enable raced by a clear is never lost
  set_wins_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ((set_bits & clear_bits) != '0) |=> ((enable_q & $past(set_bits)) == $past(set_bits)))
    else $error("clear pulse beat a set-enable write");

  clear_only_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ((clear_bits & ~set_bits) != '0)
      |=> ((enable_q & $past(clear_bits) & ~$past(set_bits)) == '0))
    else $error("clear pulse left an enable on");

  // First interrupt above the hole exercises the shifted upper map
  clear_map_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    irq_enable_clear_bits[IESR_HOLE_IRQ+1] && !set_bits[IESR_HOLE_IRQ+1] |=> !irq_en[IESR_HOLE_IRQ+1])
    else $error("clear pulse above the hole did not reach its enable");

  enable_hold_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (set_bits == '0) && (clear_bits == '0) |=> $stable(enable_q))
    else $error("enable state changed with no set or clear");

  reset_bus_a: assert property (
    @(posedge core_clk)
    !rst_n |=> hreadyout && (hrdata == IESR_RD_UNMAPPED))
    else $error("bus outputs not at rest after reset");

endmodule : iesr_top

// ==== test/tb_iesr_top.sv ====
// Purpose: Self-checking bench for the interrupt set-enable register block
// Assumes: One AHB-Lite master in the bench, hready looped back from hreadyout
// Notes:   Expected enables are kept in two bench-side words, low and high
`timescale 1ns/1ps

module tb_iesr_top
  import iesr_pkg::*;
();
  localparam logic [31:0] LOW_A  = 32'h0000_0000;
  localparam logic [31:0] HIGH_A = 32'h0000_0004;
  localparam logic [31:0] BAD_A  = 32'h0000_0008;

  logic                    core_clk;
  logic                    rst_n;
  logic                    hsel;
  logic [31:0]             haddr;
  logic [1:0]              htrans;
  logic                    hwrite;
  logic [2:0]              hsize;
  logic [31:0]             hwdata;
  logic                    hready;
  logic                    hreadyout;
  logic [31:0]             hrdata;
  logic                    hresp;
  logic [IESR_NUM_IRQ-1:0] clr_bits;
  logic [IESR_NUM_IRQ-1:0] irq_en;
  logic [31:0]             exp_lo;
  logic [31:0]             exp_hi;
  logic [31:0]             rd;
  int                      fail_count;
  int                      compares;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  iesr_top i_iesr_top (
    .core_clk              (core_clk),
    .rst_n                 (rst_n),
    .hsel                  (hsel),
    .haddr                 (haddr),
    .htrans                (htrans),
    .hwrite                (hwrite),
    .hsize                 (hsize),
    .hwdata                (hwdata),
    .hready                (hready),
    .hreadyout             (hreadyout),
    .hrdata                (hrdata),
    .hresp                 (hresp),
    .irq_enable_clear_bits (clr_bits),
    .irq_en                (irq_en)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task results;
    $display("Counts: %0d compares, %0d mismatches", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Bounded wait; a slave that never answers ends the run
  task automatic wait_ready;
    int n;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1)
    begin
      fail_count++;
      $display("MISMATCH hready expected 1 seen %b", hready);
      results();
    end
  endtask : wait_ready

  task automatic bus_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                          output logic [31:0] rdata);
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= IESR_HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= IESR_HTRANS_IDLE;
    hwdata <= wdata;
    wait_ready();
    rdata = hrdata;
    chk("hresp", 64'(IESR_HRESP_OKAY), 64'(hresp));
  endtask : bus_xfer

  task automatic check_state(input string name);
    logic [31:0] d;
    bus_xfer(1'b0, LOW_A, 32'h0, d);
    chk({name, " low word"}, {32'h0, exp_lo}, {32'h0, d});
    bus_xfer(1'b0, HIGH_A, 32'h0, d);
    chk({name, " high word"}, {32'h0, exp_hi}, {32'h0, d});
    chk({name, " irq_en"}, {14'h0, exp_hi[17:8], 1'b0, exp_hi[6:0], exp_lo}, {14'h0, irq_en});
  endtask : check_state

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    fail_count = 0;
    compares = 0;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = IESR_HTRANS_IDLE;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    clr_bits = '0;
    exp_lo = 32'h0;
    exp_hi = 32'h0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    check_state("reset");
    $display("test reset values done");
    // Each write holds zeros at bits already set, so none may drop
    // Reserved positions are always written as zero, as software must
    for (int i = 0; i < 32; i++)
    begin
      bus_xfer(1'b1, LOW_A, (32'h1 << i) & IESR_IMPL_LOW, rd);
      bus_xfer(1'b1, HIGH_A, (32'h1 << i) & IESR_IMPL_HIGH, rd);
      exp_lo = exp_lo | ((32'h1 << i) & 32'hffff_8fff);
      exp_hi = exp_hi | ((32'h1 << i) & 32'h0003_ff7f);
      check_state("walk");
    end
    bus_xfer(1'b1, LOW_A, 32'h0, rd);
    bus_xfer(1'b1, HIGH_A, 32'h0, rd);
    check_state("zero write");
    $display("test walking set done");
    @(posedge core_clk);
    clr_bits <= '1;
    @(posedge core_clk);
    clr_bits <= '0;
    exp_lo = 32'h0;
    exp_hi = 32'h0;
    bus_xfer(1'b1, BAD_A, 32'hffff_ffff, rd);
    bus_xfer(1'b0, BAD_A, 32'h0, rd);
    chk("unmapped read", 64'h0, {32'h0, rd});
    check_state("unmapped write");
    bus_xfer(1'b1, LOW_A, IESR_IMPL_LOW, rd);
    bus_xfer(1'b1, HIGH_A, IESR_IMPL_HIGH, rd);
    exp_lo = 32'hffff_8fff;
    exp_hi = 32'h0003_ff7f;
    check_state("all ones");
    $display("test reserved and unmapped done");
    // A clear landing in a write's data phase loses to the written ones
    fork
      bus_xfer(1'b1, LOW_A, 32'h0000_00ff, rd);
      begin
        @(posedge core_clk);
        clr_bits <= '1;
        @(posedge core_clk);
        clr_bits <= '0;
      end
    join
    exp_lo = 32'h0000_00ff;
    exp_hi = 32'h0;
    check_state("set beats clear");
    $display("test set against clear done");
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("irq_en in reset", 64'h0, {14'h0, irq_en});
    rst_n <= 1'b1;
    exp_lo = 32'h0;
    exp_hi = 32'h0;
    check_state("second reset");
    $display("test mid-run reset done");
    results();
  end
endmodule : tb_iesr_top
